// [hdl/xbc_pkg.sv]
package xbc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int XBC_DW = 8;
    localparam int XBC_AW = 16;
    localparam int XBC_NSYNC = 8;

    // ****************************************
    // Cycle status codes
    // ****************************************
    localparam logic [1:0] STS_HALT = 2'h0;
    localparam logic [1:0] STS_WRITE = 2'h1;
    localparam logic [1:0] STS_READ = 2'h2;
    localparam logic [1:0] STS_FETCH = 2'h3;

    // ****************************************
    // Restart addresses and reset values
    // ****************************************
    localparam logic [15:0] VEC_BOOT = 16'h0000;
    localparam logic [15:0] VEC_TRAP = 16'h0024;
    localparam logic [15:0] VEC_R75 = 16'h003C;
    localparam logic [15:0] VEC_R65 = 16'h0034;
    localparam logic [15:0] VEC_R55 = 16'h002C;
    localparam logic [2:0] MASK_RST = 3'h7;
    localparam logic [3:0] RSTOUT_CYCLES = 4'h8;

    // ****************************************
    // Set-mask word and read-mask word fields
    // ****************************************
    localparam int SIM_SOD_BIT = 7;
    localparam int SIM_SOE_BIT = 6;
    localparam int SIM_R75CLR_BIT = 4;
    localparam int SIM_MSE_BIT = 3;
    localparam int RIM_SID_BIT = 7;

    // ****************************************
    // Synchroniser bit order
    // ****************************************
    localparam int SY_READY = 0;
    localparam int SY_HOLD = 1;
    localparam int SY_TRAP = 2;
    localparam int SY_R75 = 3;
    localparam int SY_R65 = 4;
    localparam int SY_R55 = 5;
    localparam int SY_GENERAL_IRQ_IN = 6;
    localparam int SY_SID = 7;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        KIND_FETCH,
        KIND_READ,
        KIND_WRITE,
        KIND_HALT,
        KIND_IRQ_ACKNOWLEDGE_N
    } xbc_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TW,
        ST_T3,
        ST_HOLD
    } xbc_state_e;

endpackage : xbc_pkg

// [hdl/xbc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module xbc_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Raw pins and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // ****************************************
    // Three stages, accepted when last two agree
    // ****************************************
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] agree;

    assign agree = ~(s2_ff ^ s3_ff);
    assign dout = out_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= (agree & s2_ff) | (~agree & out_ff);
        end
    end

endmodule : xbc_pin_sync
`default_nettype wire

// [hdl/xbc_bus_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module xbc_bus_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Clock and reset outputs
    output logic sys_clk_out,
    output logic reset_output,
    // Multiplexed low address and data bus
    input wire logic [xbc_pkg::XBC_DW-1:0] low_addr_data_bus_in,
    output logic [xbc_pkg::XBC_DW-1:0] low_addr_data_bus_out,
    output logic low_addr_data_bus_oe,
    // High address bus
    output logic [xbc_pkg::XBC_DW-1:0] high_addr_bus,
    output logic high_addr_oe,
    // Strobes and qualifiers
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic io_m,
    output logic ctrl_oe,
    output logic cycle_status_bit0,
    output logic cycle_status_bit1,
    output logic irq_acknowledge_n,
    // Wait and bus hand-over pins
    input wire logic ready_in,
    input wire logic hold_in,
    output logic bus_grant_out,
    // Interrupt pins
    input wire logic trap_in,
    input wire logic rst75_in,
    input wire logic rst65_in,
    input wire logic rst55_in,
    input wire logic general_irq_in,
    // Serial pins
    input wire logic serial_data_input,
    output logic serial_data_output,
    // Core bus requests
    input wire logic req_valid,
    input wire xbc_pkg::xbc_kind_e req_kind,
    input wire logic req_io,
    input wire logic [xbc_pkg::XBC_AW-1:0] req_addr,
    input wire logic [xbc_pkg::XBC_DW-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_done,
    output logic [xbc_pkg::XBC_DW-1:0] rsp_data,
    output logic core_hold,
    // Core interrupt and mask commands
    input wire logic ie_set,
    input wire logic ie_clr,
    input wire logic set_mask_serial_instr,
    input wire logic [xbc_pkg::XBC_DW-1:0] sim_data,
    input wire logic read_mask_serial_instr,
    output logic [xbc_pkg::XBC_DW-1:0] rim_data,
    output logic interrupt_enable_ff,
    // Core interrupt hand-off
    output logic irq_pending,
    output logic irq_general,
    output logic [xbc_pkg::XBC_AW-1:0] irq_vector,
    input wire logic irq_take,
    output logic jump_stb,
    output logic [xbc_pkg::XBC_AW-1:0] jump_addr
);
    import xbc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    xbc_state_e state_ff;
    xbc_state_e nxt_state;
    xbc_kind_e kind_ff;
    logic ph_ff;
    logic tick;
    logic [XBC_NSYNC-1:0] pin_s;
    logic [XBC_NSYNC-1:0] pin_prev_ff;
    logic [XBC_NSYNC-1:0] pin_rise;
    logic io_ff;
    logic [XBC_AW-1:0] addr_ff;
    logic [XBC_DW-1:0] wdata_ff;
    logic [XBC_DW-1:0] rdata_ff;
    logic [1:0] status_ff;
    logic [1:0] nxt_status;
    logic accept;
    logic in_strobe;
    logic is_write;
    logic is_irq_acknowledge_n;
    logic granted;
    logic read_done;
    logic [3:0] rst_cnt_ff;
    logic rst_busy;
    logic trap_ff;
    logic r75_ff;
    logic [2:0] mask_ff;
    logic ie_ff;
    logic sod_ff;
    logic [XBC_DW-1:0] rim_ff;
    logic jump_ff;
    logic [XBC_AW-1:0] jump_addr_ff;
    logic [XBC_AW-1:0] vec_ff;
    logic trap_req;
    logic m75;
    logic m65;
    logic m55;
    logic general_irq_in_req;
    logic sel_trap;
    logic sel_75;
    logic sel_65;
    logic sel_55;
    logic sel_gen;
    logic [XBC_AW-1:0] nxt_vec;
    logic take_restart;
    logic r75_clr;
    logic sim_mask_ld;
    logic sim_sod_ld;

    // ****************************************
    // Clock halving and clock output
    // ****************************************
    // The internal state rate is one clock in two; every bus state lasts two clk periods.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_ff <= 1'b0;
        end else begin
            ph_ff <= ~ph_ff;
        end
    end

    assign tick = ph_ff;
    assign sys_clk_out = ph_ff;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    xbc_pin_sync #(
        .W(XBC_NSYNC)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({serial_data_input, general_irq_in, rst55_in, rst65_in,
              rst75_in, trap_in, hold_in, ready_in}),
        .dout(pin_s)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_prev_ff <= '0;
        end else begin
            pin_prev_ff <= pin_s;
        end
    end

    assign pin_rise = pin_s & ~pin_prev_ff;

    // ****************************************
    // Reset output stretcher
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_ff <= 4'h0;
        end else if (rst_busy) begin
            rst_cnt_ff <= rst_cnt_ff + 4'h1;
        end
    end

    assign rst_busy = (rst_cnt_ff != RSTOUT_CYCLES);
    assign reset_output = rst_busy;

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    assign granted = (state_ff == ST_HOLD);
    assign req_ready = (state_ff == ST_IDLE) && tick && !pin_s[SY_HOLD] && !rst_busy;
    assign accept = req_valid && req_ready;
    assign is_write = (kind_ff == KIND_WRITE);
    assign is_irq_acknowledge_n = (kind_ff == KIND_IRQ_ACKNOWLEDGE_N);
    assign in_strobe = (state_ff == ST_T2) || (state_ff == ST_TW);
    assign read_done = in_strobe && tick && pin_s[SY_READY] && !is_write;

    always_comb begin
        nxt_state = state_ff;
        if (tick) begin
            case (state_ff)
                ST_IDLE: begin
                    if (pin_s[SY_HOLD]) begin
                        nxt_state = ST_HOLD;
                    end else if (accept) begin
                        nxt_state = ST_T1;
                    end
                end
                ST_T1: begin
                    nxt_state = (kind_ff == KIND_HALT) ? ST_T3 : ST_T2;
                end
                ST_T2, ST_TW: begin
                    nxt_state = pin_s[SY_READY] ? ST_T3 : ST_TW;
                end
                ST_T3: begin
                    nxt_state = pin_s[SY_HOLD] ? ST_HOLD : ST_IDLE;
                end
                ST_HOLD: begin
                    nxt_state = pin_s[SY_HOLD] ? ST_HOLD : ST_IDLE;
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        case (req_kind)
            KIND_WRITE: nxt_status = STS_WRITE;
            KIND_READ: nxt_status = STS_READ;
            KIND_HALT: nxt_status = STS_HALT;
            default: nxt_status = STS_FETCH;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kind_ff <= KIND_FETCH;
            io_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= '0;
            status_ff <= STS_HALT;
        end else if (accept) begin
            kind_ff <= req_kind;
            io_ff <= req_io || (req_kind == KIND_IRQ_ACKNOWLEDGE_N);
            addr_ff <= req_addr;
            wdata_ff <= req_wdata;
            status_ff <= nxt_status;
        end
    end

    // Read data is taken in the last strobe state, before the strobe is lifted.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= '0;
        end else if (read_done) begin
            rdata_ff <= low_addr_data_bus_in;
        end
    end

    assign rsp_data = rdata_ff;
    assign rsp_done = (state_ff == ST_T3) && tick;
    assign core_hold = granted;

    // ****************************************
    // Pin drivers
    // ****************************************
    // The outside latch relies on the low byte standing until the strobe falls.
    assign ale = (state_ff == ST_T1);
    assign low_addr_data_bus_out = (state_ff == ST_T1) ? addr_ff[7:0] : wdata_ff;
    assign low_addr_data_bus_oe = (state_ff == ST_T1) || (is_write && (in_strobe || state_ff == ST_T3));
    assign high_addr_bus = addr_ff[15:8];
    assign high_addr_oe = !granted;
    assign ctrl_oe = !granted;
    assign rd_n = !(in_strobe && (kind_ff == KIND_READ || kind_ff == KIND_FETCH));
    assign wr_n = !(in_strobe && is_write);
    assign irq_acknowledge_n = !(in_strobe && is_irq_acknowledge_n);
    assign io_m = io_ff;
    assign cycle_status_bit0 = status_ff[0];
    assign cycle_status_bit1 = status_ff[1];
    assign bus_grant_out = granted;

    // ****************************************
    // Interrupt latches and masks
    // ****************************************
    assign sim_mask_ld = set_mask_serial_instr && sim_data[SIM_MSE_BIT];
    assign sim_sod_ld = set_mask_serial_instr && sim_data[SIM_SOE_BIT];
    assign r75_clr = (take_restart && sel_75) || (set_mask_serial_instr && sim_data[SIM_R75CLR_BIT]);
    assign take_restart = irq_take && !sel_gen;

    // A fresh edge in the same cycle as a clear is kept, so no request is lost.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap_ff <= 1'b0;
            r75_ff <= 1'b0;
        end else begin
            trap_ff <= pin_rise[SY_TRAP] || (trap_ff && !(take_restart && sel_trap));
            r75_ff <= pin_rise[SY_R75] || (r75_ff && !r75_clr);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_ff <= MASK_RST;
            sod_ff <= 1'b0;
            ie_ff <= 1'b0;
        end else begin
            if (sim_mask_ld) begin
                mask_ff <= sim_data[2:0];
            end
            if (sim_sod_ld) begin
                sod_ff <= sim_data[SIM_SOD_BIT];
            end
            if (ie_set) begin
                ie_ff <= 1'b1;
            end else if (ie_clr || irq_take) begin
                ie_ff <= 1'b0;
            end
        end
    end

    assign serial_data_output = sod_ff;
    assign interrupt_enable_ff = ie_ff;

    // ****************************************
    // Priority selection
    // ****************************************
    assign trap_req = trap_ff && pin_s[SY_TRAP];
    assign m75 = r75_ff && !mask_ff[2] && ie_ff;
    assign m65 = pin_s[SY_R65] && !mask_ff[1] && ie_ff;
    assign m55 = pin_s[SY_R55] && !mask_ff[0] && ie_ff;
    assign general_irq_in_req = pin_s[SY_GENERAL_IRQ_IN] && ie_ff;
    assign sel_trap = trap_req;
    assign sel_75 = !sel_trap && m75;
    assign sel_65 = !sel_trap && !m75 && m65;
    assign sel_55 = !sel_trap && !m75 && !m65 && m55;
    assign sel_gen = !sel_trap && !m75 && !m65 && !m55 && general_irq_in_req;
    assign nxt_vec = sel_trap ? VEC_TRAP : sel_75 ? VEC_R75 : sel_65 ? VEC_R65 : VEC_R55;
    assign irq_pending = sel_trap || m75 || m65 || m55 || general_irq_in_req;
    assign irq_general = sel_gen;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vec_ff <= VEC_BOOT;
        end else begin
            vec_ff <= nxt_vec;
        end
    end

    assign irq_vector = vec_ff;

    // ****************************************
    // Program start after reset or restart
    // ****************************************
    // A general request gives no address here: the core runs an acknowledge cycle instead.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            jump_ff <= 1'b0;
            jump_addr_ff <= VEC_BOOT;
        end else begin
            jump_ff <= (rst_cnt_ff == RSTOUT_CYCLES - 4'h1) || take_restart;
            if (take_restart) begin
                jump_addr_ff <= nxt_vec;
            end else if (rst_busy) begin
                jump_addr_ff <= VEC_BOOT;
            end
        end
    end

    assign jump_stb = jump_ff;
    assign jump_addr = jump_addr_ff;

    // ****************************************
    // Read-mask word
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rim_ff <= '0;
        end else if (read_mask_serial_instr) begin
            rim_ff <= {pin_s[SY_SID], r75_ff, pin_s[SY_R65], pin_s[SY_R55], ie_ff, mask_ff};
        end
    end

    assign rim_data = rim_ff;

endmodule : xbc_bus_ctrl
`default_nettype wire

// [verification/xbc_bus_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module xbc_bus_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched pins
    input wire logic reset_output,
    input wire logic low_addr_data_bus_oe,
    input wire logic high_addr_oe,
    input wire logic ctrl_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic io_m,
    input wire logic cycle_status_bit0,
    input wire logic cycle_status_bit1,
    input wire logic irq_acknowledge_n,
    input wire logic bus_grant_out,
    input wire logic serial_data_output,
    input wire logic set_mask_serial_instr,
    // Core side
    input wire logic req_valid,
    input wire xbc_pkg::xbc_kind_e req_kind,
    input wire logic req_ready
);
    import xbc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Cycles since reset release
    // ****************************************
    logic [3:0] rel_cnt_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rel_cnt_ff <= 4'h0;
        else if (rel_cnt_ff != 4'hF) rel_cnt_ff <= rel_cnt_ff + 4'h1;
    end
    // ****************************************
    // Properties
    // ****************************************
    chk_reset_out_held: assert property (rel_cnt_ff < 4'h8 |-> reset_output)
        else $error("reset output dropped early");
    chk_reset_out_ends: assert property (rel_cnt_ff > 4'h9 |-> !reset_output)
        else $error("reset output stuck high");
    chk_grant_floats_bus: assert property (bus_grant_out |-> !ctrl_oe && !high_addr_oe && !low_addr_data_bus_oe && !req_ready)
        else $error("bus driven while granted");
    chk_read_starts_latch: assert property (req_valid && req_ready && req_kind == KIND_READ |=> ale && cycle_status_bit1 && !cycle_status_bit0)
        else $error("read cycle start wrong");
    chk_write_starts_latch: assert property (req_valid && req_ready && req_kind == KIND_WRITE |=> ale && !cycle_status_bit1 && cycle_status_bit0)
        else $error("write cycle start wrong");
    chk_latch_two_clk: assert property ($rose(ale) |-> low_addr_data_bus_oe ##1 ale && low_addr_data_bus_oe ##1 !ale)
        else $error("latch strobe width wrong");
    chk_read_strobe_bus: assert property (!rd_n |-> wr_n && !low_addr_data_bus_oe && !ale && cycle_status_bit1)
        else $error("read strobe with bus driven");
    chk_write_strobe_bus: assert property (!wr_n |-> rd_n && low_addr_data_bus_oe && !cycle_status_bit1 && cycle_status_bit0)
        else $error("write strobe without data");
    chk_ack_is_io: assert property (!irq_acknowledge_n |-> io_m && !low_addr_data_bus_oe)
        else $error("acknowledge cycle wrong");
    chk_serial_out_kept: assert property (!set_mask_serial_instr |=> $stable(serial_data_output))
        else $error("serial output changed");
    cov_grant: cover property ($rose(bus_grant_out));
    cov_wait: cover property (!rd_n [*4]);
    cov_ack: cover property ($fell(irq_acknowledge_n));
endmodule : xbc_bus_ctrl_chk
bind xbc_bus_ctrl xbc_bus_ctrl_chk chk_i (.clk, .nrst, .reset_output, .low_addr_data_bus_oe, .high_addr_oe, .ctrl_oe,
    .ale, .rd_n, .wr_n, .io_m, .cycle_status_bit0, .cycle_status_bit1, .irq_acknowledge_n, .bus_grant_out,
    .serial_data_output, .set_mask_serial_instr, .req_valid, .req_kind, .req_ready);
`default_nettype wire

// [verification/xbc_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module xbc_far_side #(
    parameter int WAITS = 4,
    parameter logic [7:0] RST_OP = 8'hFF
) (
    // Clock and test control
    input wire logic clk,
    input wire logic slow,
    // Device bus pins
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ack_n,
    input wire logic oe,
    input wire logic [7:0] ad_out,
    output logic [7:0] ad_in,
    output logic ready
);
    // ****************************************
    // Memory and restart responder
    // ****************************************
    logic [7:0] mem [0:255];
    logic [7:0] lat_ff = 8'h00;
    logic [7:0] last_ff = 8'h00;
    int wcnt = 0;
    wire logic drive = !rd_n || !ack_n;
    wire logic [7:0] rdata = ack_n ? mem[lat_ff] : RST_OP;
    always @(posedge clk) begin
        if (ale) lat_ff <= ad_out;
        if (!wr_n) mem[lat_ff] <= ad_out;
        if (drive) last_ff <= rdata;
        wcnt <= (drive || !wr_n) ? wcnt + 1 : 0;
    end
    // A released bus shows the inverse of the last byte, so stale data never passes for a good read.
    assign ad_in = oe ? ad_out : drive ? rdata : ~last_ff;
    assign ready = !slow || wcnt >= WAITS;
endmodule : xbc_far_side
`default_nettype wire

// [verification/cpu8_external_bus_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu8_external_bus_control_bench;
    import xbc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0, nrst = 1'b0, slow = 1'b0, seen_io, seen_ack;
    logic sys_clk_out, reset_output, low_addr_data_bus_oe, high_addr_oe, ale, rd_n, wr_n, io_m, ctrl_oe;
    logic cycle_status_bit0, cycle_status_bit1, irq_acknowledge_n, ready_in, bus_grant_out, serial_data_output;
    logic req_ready, rsp_done, core_hold, interrupt_enable_ff, irq_pending, irq_general, jump_stb;
    logic hold_in, trap_in, rst75_in, rst65_in, rst55_in, general_irq_in, serial_data_input, req_valid, req_io;
    logic ie_set, ie_clr, set_mask_serial_instr, read_mask_serial_instr, irq_take;
    logic [7:0] low_addr_data_bus_in, low_addr_data_bus_out, high_addr_bus, rsp_data, rim_data, sim_data;
    logic [7:0] req_wdata, seen_ha;
    logic [15:0] irq_vector, jump_addr, req_addr;
    xbc_kind_e req_kind;
    int n_errors = 0, comparisons = 0, took;
    always #12.5 clk = ~clk;
    xbc_bus_ctrl uut (.clk, .nrst, .sys_clk_out, .reset_output, .low_addr_data_bus_in, .low_addr_data_bus_out,
        .low_addr_data_bus_oe, .high_addr_bus, .high_addr_oe, .ale, .rd_n, .wr_n, .io_m, .ctrl_oe, .cycle_status_bit0,
        .cycle_status_bit1, .irq_acknowledge_n, .ready_in, .hold_in, .bus_grant_out, .trap_in, .rst75_in, .rst65_in,
        .rst55_in, .general_irq_in, .serial_data_input, .serial_data_output, .req_valid, .req_kind, .req_io, .req_addr,
        .req_wdata, .req_ready, .rsp_done, .rsp_data, .core_hold, .ie_set, .ie_clr, .set_mask_serial_instr, .sim_data,
        .read_mask_serial_instr, .rim_data, .interrupt_enable_ff, .irq_pending, .irq_general, .irq_vector, .irq_take,
        .jump_stb, .jump_addr);
    xbc_far_side far (.clk(clk), .slow(slow), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ack_n(irq_acknowledge_n),
        .oe(low_addr_data_bus_oe), .ad_out(low_addr_data_bus_out), .ad_in(low_addr_data_bus_in), .ready(ready_in));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse
    task automatic sim(input logic [7:0] v);
        sim_data = v;
        pulse(set_mask_serial_instr);
    endtask : sim
    // Requests stay up until accepted; the cycle is timed from acceptance to completion.
    task automatic bus(input xbc_kind_e k, input logic io, input logic [15:0] a, input logic [7:0] d);
        req_valid = 1'b1;
        req_kind = k;
        req_io = io;
        req_addr = a;
        req_wdata = d;
        seen_ack = 1'b0;
        took = 0;
        while (req_ready !== 1'b1 && took < 99) begin
            tick(1);
            took++;
        end
        tick(1);
        req_valid = 1'b0;
        took = 1;
        while (rsp_done !== 1'b1 && took < 99) begin
            if (ale) seen_ha = high_addr_bus;
            if (!rd_n || !wr_n) seen_io = io_m;
            if (!irq_acknowledge_n) seen_ack = 1'b1;
            tick(1);
            took++;
        end
        tick(1);
    endtask : bus
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot();
        int n = 0;
        logic s;
        while (jump_stb !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk(jump_addr, VEC_BOOT, "boot address");
        chk(interrupt_enable_ff, 1'b0, "enable after reset");
        chk(bus_grant_out, 1'b0, "grant after reset");
        s = sys_clk_out;
        tick(1);
        chk(sys_clk_out, !s, "clock out toggle");
    endtask : t_boot
    task automatic t_rw();
        for (int i = 0; i < 2; i++) begin
            bus(KIND_WRITE, i[0], {8'hA5 ^ i[7:0], 8'h5A}, 8'hC3 ^ i[7:0]);
            chk(seen_io, i[0], "write qualifier");
            bus(KIND_READ, i[0], {8'hA5 ^ i[7:0], 8'h5A}, 8'h00);
            chk(rsp_data, 8'hC3 ^ i[7:0], "read back");
            chk(seen_ha, 8'hA5 ^ i[7:0], "high address");
            chk(seen_io, i[0], "read qualifier");
            chk(took, 6, "read length");
        end
    endtask : t_rw
    task automatic t_wait();
        slow = 1'b1;
        bus(KIND_FETCH, 1'b0, 16'h005A, 8'h00);
        slow = 1'b0;
        chk({cycle_status_bit1, cycle_status_bit0}, STS_FETCH, "fetch status");
        chk(took > 7, 1'b1, "wait states");
        chk(rsp_data, 8'hC2, "slow read data");
        bus(KIND_HALT, 1'b0, 16'h0000, 8'h00);
        chk(took, 4, "halt length");
        chk({cycle_status_bit1, cycle_status_bit0}, STS_HALT, "halt status");
    endtask : t_wait
    task automatic t_hold();
        int n = 0;
        hold_in = 1'b1;
        while (bus_grant_out !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        tick(3);
        chk({ctrl_oe, high_addr_oe, low_addr_data_bus_oe, req_ready}, 4'h0, "bus floated");
        chk(core_hold, 1'b1, "core suspended");
        hold_in = 1'b0;
        tick(12);
        chk(bus_grant_out, 1'b0, "grant released");
    endtask : t_hold
    task automatic t_irq();
        logic [15:0] vec [4] = '{VEC_TRAP, VEC_R75, VEC_R65, VEC_R55};
        rst55_in = 1'b1;
        sim(8'h0F);
        pulse(ie_set);
        tick(8);
        chk(irq_pending, 1'b0, "masked level");
        pulse(ie_clr);
        chk(interrupt_enable_ff, 1'b0, "enable cleared");
        sim(8'h08);
        {trap_in, rst75_in, rst65_in, general_irq_in} = 4'hF;
        pulse(ie_set);
        tick(8);
        for (int i = 0; i < 4; i++) begin
            chk(irq_vector, vec[i], "priority order");
            pulse(irq_take);
            tick(1);
            chk(jump_addr, vec[i], "restart address");
            trap_in = 1'b0;
            rst75_in = 1'b0;
            if (i == 2) rst65_in = 1'b0;
            if (i == 3) rst55_in = 1'b0;
            pulse(ie_set);
            tick(8);
        end
        chk(irq_general, 1'b1, "general request");
        pulse(irq_take);
        general_irq_in = 1'b0;
        bus(KIND_IRQ_ACKNOWLEDGE_N, 1'b1, 16'h0000, 8'h00);
        chk(seen_ack, 1'b1, "acknowledge strobe");
        chk(rsp_data, 8'hFF, "restart opcode read");
    endtask : t_irq
    task automatic t_serial();
        sim(8'hC0);
        chk(serial_data_output, 1'b1, "serial set");
        sim(8'h00);
        chk(serial_data_output, 1'b1, "serial unchanged");
        sim(8'h40);
        chk(serial_data_output, 1'b0, "serial cleared");
        for (int b = 0; b < 2; b++) begin
            serial_data_input = b[0];
            tick(8);
            pulse(read_mask_serial_instr);
            chk(rim_data[RIM_SID_BIT], b[0], "serial input bit");
        end
    endtask : t_serial
    // ****************************************
    // Run control
    // ****************************************
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #(25 * 20000);
        n_errors++;
        print_verdict();
    end
    initial begin
        {hold_in, trap_in, rst75_in, rst65_in, rst55_in, general_irq_in, serial_data_input} = '0;
        {req_valid, req_io, ie_set, ie_clr, set_mask_serial_instr, read_mask_serial_instr, irq_take} = '0;
        req_kind = KIND_READ;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
        sim_data = 8'h00;
        tick(12);
        chk(reset_output, 1'b1, "reset out high");
        chk(sys_clk_out, 1'b0, "clock out in reset");
        nrst = 1'b1;
        t_boot();
        t_rw();
        t_wait();
        t_hold();
        t_irq();
        t_serial();
        print_verdict();
    end
endmodule : cpu8_external_bus_control_bench
`default_nettype wire
